// ### rtl/load_ctrl_defines.vh
// Constants of the two-channel load current controller: offsets, fields, resets, timing.
// Assumes a 250 MHz ref_clk and a converter that presents one 8-bit code at a time.
// How it works
// - Read-only word: channel 2 decimated sample high byte, channel 1 low byte.
// - Mode bit 0 resets to 0; 0 low idle, 1 high idle; bits 15:1 reserved.
// - Low idle: nonzero code at or below threshold sinks the low code.
// - Low idle: code above the rising threshold switches the sink to the high code.
// - High idle: any nonzero code sinks the high code.
// - Each channel decides alone and drives only its own sink output.
// - Rising threshold is an 8-bit field resetting to 0x1e; upper byte reserved.
// - Threshold writes of 0x00 store 0x01 and of 0xff store 0xfe.
// - Low code is a 6-bit field resetting to 0x1e, 100 uA per step.
// - A low code write of zero stores one.
// - High code is an 8-bit field resetting to 0xc8, 200 uA per step.
// - High current lasts the 12-bit period times 10 us; period resets to 0x12c.
// - A period write of zero stores one.
// - Raw samples at 100 kHz alternate channels, so each refreshes at 50 kHz.
// - Load enables at bits 14 and 15, cleared after reset.
`ifndef LOAD_CTRL_DEFINES_VH
`define LOAD_CTRL_DEFINES_VH

`define ADDR_RAW_SAMPLES     10'h00e
`define ADDR_DEC_SAMPLES     10'h00f
`define ADDR_MODE_CTRL       10'h010
`define ADDR_RISING_THRESHOLD        10'h011
`define ADDR_LOW_CODE        10'h012
`define ADDR_HIGH_CODE       10'h013
`define ADDR_HIGH_PERIOD     10'h014
`define ADDR_LOAD_ENABLE     10'h200

`define MODE_BIT             0
`define EN_CH1_BIT           14
`define EN_CH2_BIT           15

`define RST_MODE             1'h0
`define RST_RISING_THRESHOLD         8'h1e
`define RST_LOW_CODE         6'h1e
`define RST_HIGH_CODE        8'hc8
`define RST_HIGH_PERIOD      12'h12c

`define THR_MIN              8'h01
`define THR_MAX              8'hfe
`define LOW_CODE_MIN         6'h01
`define PERIOD_MIN           12'h001

`define CLK_MHZ              250
`define HIGH_UNIT_US         10
`define SAMPLE_RATE_KHZ      100
`define CYC_PER_UNIT         (`CLK_MHZ * `HIGH_UNIT_US)
`define CYC_PER_SAMPLE       ((`CLK_MHZ * 1000) / `SAMPLE_RATE_KHZ)

`endif

// ### rtl/sample_decimator.v
// Keeps one decimated sample per channel from the interleaved raw sample stream.
// Assumes one sample_valid pulse per raw sample, tagged with its channel.
`timescale 1ns/1ps
`default_nettype none
module sample_decimator #(
    parameter RATE_W = 4
) (
    input  wire              ref_clk,
    input  wire              resetn,
    input  wire              sample_valid,
    input  wire              sample_ch,
    input  wire [7:0]        sample_data,
    input  wire [RATE_W-1:0] decimation_rate,
    output wire [15:0]       dec_word
);
    reg [RATE_W-1:0] skip_r [0:1];
    reg [7:0]        dec_r  [0:1];
    integer          i;

    // Rate N keeps one sample in N+1; rate 0 passes every sample.
    always @(posedge ref_clk) begin
        if (!resetn) begin
            for (i = 0; i < 2; i = i + 1) begin
                skip_r[i] <= {RATE_W{1'b0}};
                dec_r[i]  <= 8'h00;
            end
        end else if (sample_valid) begin
            if (skip_r[sample_ch] >= decimation_rate) begin
                skip_r[sample_ch] <= {RATE_W{1'b0}};
                dec_r[sample_ch]  <= sample_data;
            end else begin
                skip_r[sample_ch] <= skip_r[sample_ch] + 1'b1;
            end
        end
    end

    assign dec_word = {dec_r[1], dec_r[0]};
endmodule // sample_decimator
`default_nettype wire

// ### rtl/sink_channel.v
// One channel's sink decision and high-current timer.
// Assumes sample_valid pulses once per fresh code of this channel.
`timescale 1ns/1ps
`default_nettype none
module sink_channel #(
    parameter CYC_PER_UNIT = 2500
) (
    input  wire        ref_clk,
    input  wire        resetn,
    input  wire        enable,
    input  wire        high_idle,
    input  wire        sample_valid,
    input  wire [7:0]  adc_code,
    input  wire [7:0]  rising_threshold,
    input  wire [5:0]  low_code,
    input  wire [7:0]  high_code,
    input  wire [11:0] high_period,
    output reg  [7:0]  sink_code_r,
    output reg         sink_high_r
);
    localparam ST_OFF   = 4'b0001;
    localparam ST_LOW   = 4'b0010;
    localparam ST_HIGH  = 4'b0100;
    localparam ST_SPENT = 4'b1000;

    reg [3:0]  state_r;
    reg [3:0]  state_nxt;
    reg [11:0] unit_r;
    reg [15:0] sub_r;
    wire       unit_end = (sub_r == CYC_PER_UNIT - 1);
    wire       expire   = state_r[2] && unit_end && (unit_r == 12'h001);

    always @* begin
        state_nxt = state_r;
        if (!enable) begin
            state_nxt = ST_OFF;
        end else if (sample_valid && adc_code == 8'h00) begin
            state_nxt = ST_OFF;
        end else if (expire) begin
            state_nxt = ST_SPENT;
        end else if (sample_valid) begin
            case (state_r)
                ST_OFF, ST_LOW: begin
                    if (high_idle || adc_code > rising_threshold)
                        state_nxt = ST_HIGH;
                    else
                        state_nxt = ST_LOW;
                end
                ST_HIGH: state_nxt = ST_HIGH;
                // The pulse rearms only after the code falls back to the threshold.
                ST_SPENT: begin
                    if (!high_idle && adc_code <= rising_threshold)
                        state_nxt = ST_LOW;
                end
                default: state_nxt = ST_OFF;
            endcase
        end
    end

    always @(posedge ref_clk) begin
        if (!resetn) begin
            state_r     <= ST_OFF;
            unit_r      <= 12'h000;
            sub_r       <= 16'h0000;
            sink_code_r <= 8'h00;
            sink_high_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            if (state_nxt[2] && !state_r[2]) begin
                unit_r <= high_period;
                sub_r  <= 16'h0000;
            end else if (state_r[2]) begin
                sub_r <= unit_end ? 16'h0000 : sub_r + 16'h0001;
                if (unit_end)
                    unit_r <= unit_r - 12'h001;
            end
            sink_high_r <= state_nxt[2];
            case (state_nxt)
                ST_LOW:   sink_code_r <= {2'b00, low_code};
                ST_HIGH:  sink_code_r <= high_code;
                ST_SPENT: sink_code_r <= high_idle ? 8'h00 : {2'b00, low_code};
                default:  sink_code_r <= 8'h00;
            endcase
        end
    end
endmodule // sink_channel
`default_nettype wire

// ### rtl/load_current_ctrl.v
// Register bank and sample scheduling of the two-channel load current controller.
// Assumes a same-clock register port and a converter whose code follows adc_sel.
`timescale 1ns/1ps
`default_nettype none
`include "load_ctrl_defines.vh"
module load_current_ctrl #(
    parameter RATE_W = 4
) (
    input  wire              ref_clk,
    input  wire              resetn,
    input  wire [9:0]        reg_addr,
    input  wire [15:0]       reg_wdata,
    input  wire              reg_wr,
    input  wire              reg_rd,
    output reg  [15:0]       reg_rdata_r,
    output reg               reg_rvalid_r,
    output reg               reg_miss_r,
    input  wire [RATE_W-1:0] decimation_rate,
    input  wire [7:0]        adc_data,
    output reg               adc_sel_r,
    output reg               adc_convert_r,
    output wire [7:0]        ch1_sink_output,
    output wire [7:0]        ch2_sink_output,
    output wire              ch1_sink_high,
    output wire              ch2_sink_high,
    output reg               ch1_sink_enable,
    output reg               ch2_sink_enable
);
    localparam [15:0] CYC_SAMPLE = `CYC_PER_SAMPLE;

    reg         load_idle_mode_r;
    reg  [7:0]  rising_threshold_r;
    reg  [5:0]  low_code_r;
    reg  [7:0]  high_code_r;
    reg  [11:0] high_period_r;
    reg  [15:0] div_r;
    reg  [7:0]  raw_r [0:1];
    reg         sample_valid_r;
    reg         sample_ch_r;
    wire [15:0] dec_word;

    // Write clamps keep the threshold, low code and period fields inside their legal ranges.
    function [7:0] clamp_thr;
        input [7:0] v;
        begin
            if (v == 8'h00)
                clamp_thr = `THR_MIN;
            else if (v == 8'hff)
                clamp_thr = `THR_MAX;
            else
                clamp_thr = v;
        end
    endfunction

    function [5:0] clamp_low;
        input [5:0] v;
        begin
            clamp_low = (v == 6'h00) ? `LOW_CODE_MIN : v;
        end
    endfunction

    function [11:0] clamp_period;
        input [11:0] v;
        begin
            clamp_period = (v == 12'h000) ? `PERIOD_MIN : v;
        end
    endfunction

    // Zero is stored as written: the host keeps high codes nonzero.
    always @(posedge ref_clk) begin
        if (!resetn) begin
            load_idle_mode_r   <= `RST_MODE;
            rising_threshold_r <= `RST_RISING_THRESHOLD;
            low_code_r         <= `RST_LOW_CODE;
            high_code_r        <= `RST_HIGH_CODE;
            high_period_r      <= `RST_HIGH_PERIOD;
            ch1_sink_enable    <= 1'b0;
            ch2_sink_enable    <= 1'b0;
        end else if (reg_wr) begin
            case (reg_addr)
                `ADDR_MODE_CTRL:
                    load_idle_mode_r <= reg_wdata[`MODE_BIT];
                `ADDR_RISING_THRESHOLD:
                    rising_threshold_r <= clamp_thr(reg_wdata[7:0]);
                `ADDR_LOW_CODE:
                    low_code_r <= clamp_low(reg_wdata[5:0]);
                `ADDR_HIGH_CODE:
                    high_code_r <= reg_wdata[7:0];
                `ADDR_HIGH_PERIOD:
                    high_period_r <= clamp_period(reg_wdata[11:0]);
                `ADDR_LOAD_ENABLE: begin
                    ch1_sink_enable <= reg_wdata[`EN_CH1_BIT];
                    ch2_sink_enable <= reg_wdata[`EN_CH2_BIT];
                end
                default: ;
            endcase
        end
    end

    // Reads answer one cycle later; an unmapped address reads zero and flags a miss.
    always @(posedge ref_clk) begin
        if (!resetn) begin
            reg_rdata_r  <= 16'h0000;
            reg_rvalid_r <= 1'b0;
            reg_miss_r   <= 1'b0;
        end else begin
            reg_rvalid_r <= reg_rd;
            reg_miss_r   <= 1'b0;
            if (reg_rd) begin
                case (reg_addr)
                    `ADDR_RAW_SAMPLES:
                        reg_rdata_r <= {raw_r[1], raw_r[0]};
                    `ADDR_DEC_SAMPLES:
                        reg_rdata_r <= dec_word;
                    `ADDR_MODE_CTRL:
                        reg_rdata_r <= {15'h0000, load_idle_mode_r};
                    `ADDR_RISING_THRESHOLD:
                        reg_rdata_r <= {8'h00, rising_threshold_r};
                    `ADDR_LOW_CODE:
                        reg_rdata_r <= {10'h000, low_code_r};
                    `ADDR_HIGH_CODE:
                        reg_rdata_r <= {8'h00, high_code_r};
                    `ADDR_HIGH_PERIOD:
                        reg_rdata_r <= {4'h0, high_period_r};
                    `ADDR_LOAD_ENABLE:
                        reg_rdata_r <= {ch2_sink_enable, ch1_sink_enable, 14'h0000};
                    default: begin
                        reg_rdata_r <= 16'h0000;
                        reg_miss_r  <= 1'b1;
                    end
                endcase
            end
        end
    end

    // One conversion every 10 us alternates the channels, 50 kHz per channel.
    always @(posedge ref_clk) begin
        if (!resetn) begin
            div_r          <= 16'h0000;
            adc_sel_r      <= 1'b0;
            adc_convert_r  <= 1'b0;
            sample_valid_r <= 1'b0;
            sample_ch_r    <= 1'b0;
            raw_r[0]       <= 8'h00;
            raw_r[1]       <= 8'h00;
        end else begin
            adc_convert_r  <= 1'b0;
            sample_valid_r <= 1'b0;
            if (div_r == CYC_SAMPLE - 16'h0001) begin
                div_r            <= 16'h0000;
                raw_r[adc_sel_r] <= adc_data;
                sample_ch_r      <= adc_sel_r;
                sample_valid_r   <= 1'b1;
                adc_sel_r        <= ~adc_sel_r;
                adc_convert_r    <= 1'b1;
            end else begin
                div_r <= div_r + 16'h0001;
            end
        end
    end

    sample_decimator #(
        .RATE_W (RATE_W)
    ) u_dec (
        .ref_clk         (ref_clk),
        .resetn          (resetn),
        .sample_valid    (sample_valid_r),
        .sample_ch       (sample_ch_r),
        .sample_data     (raw_r[sample_ch_r]),
        .decimation_rate (decimation_rate),
        .dec_word        (dec_word)
    );

    // Each channel sees only its own code and drives only its own sink.
    sink_channel #(
        .CYC_PER_UNIT (`CYC_PER_UNIT)
    ) u_ch1 (
        .ref_clk      (ref_clk),
        .resetn       (resetn),
        .enable       (ch1_sink_enable),
        .high_idle    (load_idle_mode_r),
        .sample_valid (sample_valid_r && !sample_ch_r),
        .adc_code     (raw_r[0]),
        .rising_threshold     (rising_threshold_r),
        .low_code     (low_code_r),
        .high_code    (high_code_r),
        .high_period  (high_period_r),
        .sink_code_r  (ch1_sink_output),
        .sink_high_r  (ch1_sink_high)
    );

    sink_channel #(
        .CYC_PER_UNIT (`CYC_PER_UNIT)
    ) u_ch2 (
        .ref_clk      (ref_clk),
        .resetn       (resetn),
        .enable       (ch2_sink_enable),
        .high_idle    (load_idle_mode_r),
        .sample_valid (sample_valid_r && sample_ch_r),
        .adc_code     (raw_r[1]),
        .rising_threshold     (rising_threshold_r),
        .low_code     (low_code_r),
        .high_code    (high_code_r),
        .high_period  (high_period_r),
        .sink_code_r  (ch2_sink_output),
        .sink_high_r  (ch2_sink_high)
    );
endmodule // load_current_ctrl
`default_nettype wire

// ### verif/load_ctrl_sva.sv
// Concurrent checks on the load controller's register port, sampler and sink outputs.
// Assumes it is bound to load_current_ctrl and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module load_ctrl_sva (
    input wire logic        ref_clk,
    input wire logic        resetn,
    input wire logic [9:0]  reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic        reg_wr,
    input wire logic        reg_rd,
    input wire logic [15:0] reg_rdata_r,
    input wire logic        reg_rvalid_r,
    input wire logic        reg_miss_r,
    input wire logic        adc_sel_r,
    input wire logic        adc_convert_r,
    input wire logic [7:0]  ch1_sink_output,
    input wire logic        ch1_sink_high,
    input wire logic        ch1_sink_enable,
    input wire logic [7:0]  ch2_sink_output,
    input wire logic        ch2_sink_enable
);
    logic [7:0]  hc_r;
    logic [15:0] wd_r;
    logic [11:0] gap_r;
    logic        seen_r;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!resetn);
    // Shadows of host writes plus a count of cycles since the last conversion, so read data, sink codes and sample spacing can be checked.
    always @(posedge ref_clk) begin
        if (!resetn) begin
            hc_r   <= 8'hc8;
            wd_r   <= 16'h0000;
            gap_r  <= 12'h000;
            seen_r <= 1'b0;
        end else begin
            if (reg_wr && reg_addr == 10'h013) hc_r <= reg_wdata[7:0];
            if (reg_wr) wd_r <= reg_wdata;
            gap_r  <= adc_convert_r ? 12'h000 : gap_r + 12'h001;
            seen_r <= seen_r | adc_convert_r;
        end
    end
    sequence wr_rd(a);
        reg_wr && reg_addr == a ##1 reg_rd && !reg_wr && reg_addr == a;
    endsequence
    thr_clamp_a:
    assert property (wr_rd(10'h011) |=> reg_rdata_r == {8'h00, wd_r[7:0] == 8'h00 ? 8'h01 :
        wd_r[7:0] == 8'hff ? 8'hfe : wd_r[7:0]}) else $error("threshold clamp wrong");
    low_clamp_a:
    assert property (wr_rd(10'h012) |=> reg_rdata_r == {10'h000,
        wd_r[5:0] == 6'h00 ? 6'h01 : wd_r[5:0]}) else $error("low code clamp wrong");
    period_clamp_a:
    assert property (wr_rd(10'h014) |=> reg_rdata_r == {4'h0,
        wd_r[11:0] == 12'h000 ? 12'h001 : wd_r[11:0]}) else $error("period clamp wrong");
    mode_reserved_a:
    assert property (reg_rd && reg_addr == 10'h010 |=> reg_rdata_r[15:1] == 15'h0000)
        else $error("mode reserved bits set");
    unmapped_read_a:
    assert property (reg_rd && reg_addr == 10'h3ff |=> reg_rvalid_r && reg_miss_r
        && reg_rdata_r == 16'h0000) else $error("unmapped read wrong");
    sample_gap_a:
    assert property (adc_convert_r && seen_r |-> gap_r == 12'h9c3) else $error("sample gap wrong");
    sel_toggle_a:
    assert property (adc_convert_r |-> adc_sel_r != $past(adc_sel_r)) else $error("no channel swap");
    high_code_a:
    assert property ($rose(ch1_sink_high) |-> ch1_sink_output == hc_r) else $error("high code wrong");
    ch1_off_a:
    assert property (!ch1_sink_enable |=> ch1_sink_output == 8'h00) else $error("ch1 sinks disabled");
    ch2_off_a:
    assert property (!ch2_sink_enable |=> ch2_sink_output == 8'h00) else $error("ch2 sinks disabled");
endmodule // load_ctrl_sva
bind load_current_ctrl load_ctrl_sva load_ctrl_sva_i (.ref_clk, .resetn, .reg_addr, .reg_wdata,
    .reg_wr, .reg_rd, .reg_rdata_r, .reg_rvalid_r, .reg_miss_r, .adc_sel_r, .adc_convert_r,
    .ch1_sink_output, .ch1_sink_high, .ch1_sink_enable, .ch2_sink_output, .ch2_sink_enable);
`default_nettype wire

// ### verif/adc_stub.sv
// Converter stand-in: presents the code of the channel the controller selects.
// Assumes the bench changes the two channel codes at clock edges.
`timescale 1ns/1ps
`default_nettype none
module adc_stub (
    input  wire logic       adc_sel_r,
    input  wire logic [7:0] code1,
    input  wire logic [7:0] code2,
    output wire logic [7:0] adc_data
);
    // Combinational, since the controller captures in the cycle it selects.
    assign adc_data = adc_sel_r ? code2 : code1;
endmodule // adc_stub
`default_nettype wire

// ### verif/tb_dual_channel_load_current_control.sv
// Self-checking bench of the load controller: registers, clamps, sampling and sinks.
// Assumes the converter stand-in and the bound checker are compiled alongside.
`timescale 1ns/1ps
`default_nettype none
module tb_dual_channel_load_current_control;
    logic        ref_clk = 1'b0;
    logic        resetn = 1'b0;
    logic [9:0]  reg_addr = 10'h000;
    logic [15:0] reg_wdata = 16'h0000;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    logic [3:0]  decimation_rate = 4'h0;
    logic [7:0]  code1 = 8'h00;
    logic [7:0]  code2 = 8'h00;
    wire  [15:0] reg_rdata_r;
    wire  [7:0]  adc_data, ch1_sink_output, ch2_sink_output;
    wire         reg_rvalid_r, reg_miss_r, adc_sel_r, adc_convert_r;
    wire         ch1_sink_high, ch2_sink_high, ch1_sink_enable, ch2_sink_enable;
    int          n_fail = 0;
    int          compares = 0;
    logic [31:0] seed = 32'hee10;
    logic [15:0] d;
    int          i, j, n;
    logic [9:0]  regs [0:5] = '{10'h010, 10'h011, 10'h012, 10'h013, 10'h014, 10'h200};
    logic [15:0] rstv [0:5] = '{16'h0000, 16'h001e, 16'h001e, 16'h00c8, 16'h012c, 16'h0000};
    always #2 ref_clk = ~ref_clk;
    load_current_ctrl load_current_ctrl_i (.ref_clk, .resetn, .reg_addr, .reg_wdata, .reg_wr,
        .reg_rd, .reg_rdata_r, .reg_rvalid_r, .reg_miss_r, .decimation_rate, .adc_data,
        .adc_sel_r, .adc_convert_r, .ch1_sink_output, .ch2_sink_output, .ch1_sink_high,
        .ch2_sink_high, .ch1_sink_enable, .ch2_sink_enable);
    adc_stub adc_stub_i (.adc_sel_r, .code1, .code2, .adc_data);
    function automatic [31:0] xs(input [31:0] x);
        x = x ^ (x << 13);
        x = x ^ (x >> 17);
        xs = x ^ (x << 5);
    endfunction
    function automatic [15:0] expv(input [9:0] a, input [15:0] v);
        case (a)
            10'h010: expv = {15'h0000, v[0]};
            10'h011: expv = {8'h00, v[7:0] == 8'h00 ? 8'h01 : v[7:0] == 8'hff ? 8'hfe : v[7:0]};
            10'h012: expv = {10'h000, v[5:0] == 6'h00 ? 6'h01 : v[5:0]};
            10'h013: expv = {8'h00, v[7:0]};
            10'h014: expv = {4'h0, v[11:0] == 12'h000 ? 12'h001 : v[11:0]};
            default: expv = {v[15:14], 14'h0000};
        endcase
    endfunction
    task automatic test_done;
        $display("compares=%0d n_fail=%0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task automatic chk(input [15:0] got, input [15:0] exp);
        compares++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected at %0t: got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic rd(input [9:0] a, input [15:0] e);
        @(posedge ref_clk) begin reg_rd <= 1'b1; reg_addr <= a; end
        @(posedge ref_clk) reg_rd <= 1'b0;
        #1;
        chk({14'h0, reg_rvalid_r, reg_miss_r}, {14'h0, 1'b1, a == 10'h3ff});
        chk(reg_rdata_r, e);
    endtask
    // Write then read back at once, the tightest spacing the port allows.
    task automatic wrd(input [9:0] a, input [15:0] v, input [15:0] e);
        @(posedge ref_clk) begin reg_wr <= 1'b1; reg_addr <= a; reg_wdata <= v; end
        @(posedge ref_clk) begin reg_wr <= 1'b0; reg_rd <= 1'b1; end
        @(posedge ref_clk) reg_rd <= 1'b0;
        #1;
        chk(reg_rdata_r, e);
    endtask
    // Waits for the capture of channel ch (sel has already moved on), then settles.
    task automatic wait_ch(input logic ch, input int settle);
        for (n = 0; n < 6000; n++) begin
            @(posedge ref_clk);
            #1;
            if (adc_convert_r === 1'b1 && adc_sel_r !== ch) break;
        end
        if (n == 6000) begin n_fail++; test_done; end
        repeat (settle) @(posedge ref_clk);
        #1;
    endtask
    initial begin
        repeat (10) @(posedge ref_clk);
        resetn <= 1'b1;
        for (i = 0; i < 6; i++) rd(regs[i], rstv[i]);
        rd(10'h3ff, 16'h0000);
        for (i = 0; i < 6; i++) begin
            for (j = 0; j < 6; j++) begin
                seed = xs(seed);
                d = (j == 0) ? 16'h0000 : (j == 1) ? 16'hffff : seed[15:0];
                if (regs[i] == 10'h013 && d[7:0] == 8'h00) d[0] = 1'b1;
                wrd(regs[i], d, expv(regs[i], d));
            end
        end
        wrd(10'h010, 16'h0000, 16'h0000);
        wrd(10'h011, 16'h0040, 16'h0040);
        wrd(10'h012, 16'h0005, 16'h0005);
        wrd(10'h013, 16'h0033, 16'h0033);
        wrd(10'h014, 16'h0000, 16'h0001);
        wrd(10'h200, 16'hc000, 16'hc000);
        @(posedge ref_clk) code1 <= 8'h20;
        wait_ch(1'b1, 0);
        wait_ch(1'b0, 3);
        chk(ch1_sink_output, 16'h0005);
        chk(ch2_sink_output, 16'h0000);
        rd(10'h00e, 16'h0020);
        rd(10'h00f, 16'h0020);
        wrd(10'h00f, 16'hffff, 16'h0020);
        @(posedge ref_clk) code1 <= 8'h40;
        wait_ch(1'b0, 3);
        chk(ch1_sink_output, 16'h0005);
        @(posedge ref_clk) code1 <= 8'h41;
        wait_ch(1'b0, 0);
        j = 0;
        for (i = 0; i < 6000; i++) begin
            @(posedge ref_clk);
            #1;
            if (ch1_sink_high === 1'b1) j++;
            else if (j > 0) break;
        end
        chk(j, 16'd2500);
        chk(ch1_sink_output, 16'h0005);
        // A longer pulse, so that the zero code below ends it before the timer does.
        wrd(10'h014, 16'h0003, 16'h0003);
        wrd(10'h010, 16'h0001, 16'h0001);
        @(posedge ref_clk) code2 <= 8'h10;
        wait_ch(1'b1, 3);
        chk({ch2_sink_high, ch2_sink_output}, 16'h0133);
        @(posedge ref_clk) code2 <= 8'h00;
        wait_ch(1'b1, 3);
        chk({ch2_sink_high, ch2_sink_output}, 16'h0000);
        wrd(10'h010, 16'h0000, 16'h0000);
        chk(ch1_sink_output, 16'h0005);
        wrd(10'h200, 16'h0000, 16'h0000);
        chk(ch1_sink_output, 16'h0000);
        // Rate 1 keeps every second sample of a channel.
        @(posedge ref_clk) begin decimation_rate <= 4'h1; code1 <= 8'h55; end
        wait_ch(1'b0, 3);
        rd(10'h00f, 16'h0041);
        wait_ch(1'b0, 3);
        rd(10'h00f, 16'h0055);
        test_done;
    end
endmodule // tb_dual_channel_load_current_control
`default_nettype wire
